/* File: design/adc_conversion_pkg.sv */
package adc_conversion_pkg;

    // ------------------------------------------------------------------
    // register map: printed offsets are word indices, byte address = 4x
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [7:0] CONTROL_INDEX = 8'hE1;
    localparam logic [7:0] RESULT_HIGH_INDEX = 8'hE2;
    localparam logic [7:0] RESULT_LOW_INDEX = 8'hE3;
    localparam logic [7:0] EVENT_STATUS_INDEX = 8'hF0;
    localparam logic [7:0] EVENT_MASK_INDEX = 8'hF1;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = {2'h0, CONTROL_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] RESULT_HIGH_ADDR = {2'h0, RESULT_HIGH_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] RESULT_LOW_ADDR = {2'h0, RESULT_LOW_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = {2'h0, EVENT_STATUS_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = {2'h0, EVENT_MASK_INDEX, 2'h0};

    // ------------------------------------------------------------------
    // converter_control field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_EXT_START_BIT = 5;
    localparam int CTRL_DONE_BIT = 4;
    localparam int CTRL_START_BIT = 3;
    localparam int CTRL_CHAN_LSB = 0;
    localparam int CHAN_W = 3;
    localparam int CHANNELS = 8;

    // ------------------------------------------------------------------
    // result fields and conversion clock select
    // ------------------------------------------------------------------
    localparam int RESULT_W = 10;
    localparam int LOW_CLKSEL_LSB = 6;
    localparam int CLKSEL_W = 2;
    localparam logic [1:0] CLKSEL_DIV4 = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV16 = 2'h2;
    localparam int DIV_CNT_W = 4;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] DIV8_LAST = 4'h7;
    localparam logic [3:0] DIV16_LAST = 4'hF;

    // ------------------------------------------------------------------
    // event status / mask layout and reset values
    // ------------------------------------------------------------------
    localparam int EVT_W = 3;
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_ABORT_BIT = 1;
    localparam int EVT_REFUSED_BIT = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] CLKSEL_RESET = 2'h0;
    localparam logic [2:0] EVT_MASK_RESET = 3'h0;

endpackage : adc_conversion_pkg

/* File: design/conv_clock_divider.sv */
`timescale 1ns/100ps
module conv_clock_divider (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] clock_select,
    output logic tick
);

    // ------------------------------------------------------------------
    // divider state
    // ------------------------------------------------------------------
    logic [adc_conversion_pkg::DIV_CNT_W-1:0] count;
    logic [adc_conversion_pkg::DIV_CNT_W-1:0] next_count;
    logic [adc_conversion_pkg::DIV_CNT_W-1:0] last;
    logic next_tick;

    // terminal count per select code; reserved code runs as slowest so a
    // stray setting never stalls a conversion
    always_comb begin
        unique case (clock_select)
            adc_conversion_pkg::CLKSEL_DIV4: last = adc_conversion_pkg::DIV4_LAST; // R12
            adc_conversion_pkg::CLKSEL_DIV8: last = adc_conversion_pkg::DIV8_LAST; // R12
            adc_conversion_pkg::CLKSEL_DIV16: last = adc_conversion_pkg::DIV16_LAST; // R12
            default: last = adc_conversion_pkg::DIV16_LAST;
        endcase
        next_tick = 1'b0;
        next_count = count + 4'h1;
        if (!run) begin
            next_count = '0;
        end else if (count >= last) begin
            next_count = '0;
            next_tick = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

endmodule : conv_clock_divider

/* File: design/adc_conversion_control.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
// How it works
// R1 - nothing converts unless the block enable bit is one.
// R2 - with external start enabled a rising trigger edge starts a conversion, else it is ignored.
// R3 - the done flag is set by hardware when a conversion completes.
// R4 - the interrupt is high while the done flag is set and its mask bit is on.
// R5 - only a software write of zero clears the done flag, hardware never does.
// R6 - writing zero to start/busy during a conversion aborts it.
// R7 - no new start is taken while start/busy or done is one.
// R8 - software should clear done in a write before the one that sets start.
// R9 - a single write clearing done and setting start may begin a conversion.
// R10 - start/busy and done read back as idle, busy or complete.
// R11 - the 10-bit result reads as high byte plus bits 1:0 of the low byte.
// R12 - a 2-bit field picks the conversion clock as clk/4, clk/8 or clk/16.
// R13 - the 3-bit channel field routes input 0..7 to the converter.
// R14 - setting start when idle and enabled begins a conversion; busy drops as done rises.
module adc_conversion_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_conversion_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic external_trigger_pin,
    input wire logic core_done,
    input wire logic [adc_conversion_pkg::RESULT_W-1:0] core_result,
    output logic core_start,
    output logic core_abort,
    output logic [adc_conversion_pkg::CHAN_W-1:0] core_channel,
    output logic [adc_conversion_pkg::CHANNELS-1:0] core_input_enable,
    output logic core_clk_en
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic converter_block_enable;
    logic external_start_enable;
    logic conversion_done_flag;
    logic conversion_start_busy;
    logic [adc_conversion_pkg::CHAN_W-1:0] input_channel_select;
    logic [adc_conversion_pkg::CLKSEL_W-1:0] conversion_clock_select;
    logic [adc_conversion_pkg::RESULT_W-1:0] result;
    logic [adc_conversion_pkg::EVT_W-1:0] event_status;
    logic [adc_conversion_pkg::EVT_W-1:0] event_mask;
    logic next_enable, next_ext_en, next_done, next_busy;
    logic [adc_conversion_pkg::CHAN_W-1:0] next_chan, next_core_channel;
    logic [adc_conversion_pkg::CLKSEL_W-1:0] next_clksel;
    logic [adc_conversion_pkg::RESULT_W-1:0] next_result;
    logic [adc_conversion_pkg::EVT_W-1:0] next_status, next_mask, evt_set;
    logic next_core_start, next_core_abort, next_irq;
    logic [adc_conversion_pkg::CHANNELS-1:0] next_input_enable;
    logic trig_meta, trig_sync, trig_prev, trig_rise;
    logic next_pready, next_pslverr;
    logic [31:0] next_prdata, read_word;
    logic access, wr_ctrl, wr_low, wr_mask, rd_status, mapped;
    logic en_now, done_kept, start_sw, start_ext, abort, complete, refused;
    logic [adc_conversion_pkg::CLKSEL_W-1:0] clksel_raw;

    // ------------------------------------------------------------------
    // external trigger synchroniser and edge detect
    // ------------------------------------------------------------------
    // the pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= external_trigger_pin;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    assign trig_rise = trig_sync & ~trig_prev;

    // ------------------------------------------------------------------
    // apb slave: one wait state, write and read-clear at the ready edge
    // ------------------------------------------------------------------
    assign access = psel & penable & pready;
    assign wr_ctrl = access & pwrite & (paddr == adc_conversion_pkg::CONTROL_ADDR);
    assign wr_low = access & pwrite & (paddr == adc_conversion_pkg::RESULT_LOW_ADDR);
    assign wr_mask = access & pwrite & (paddr == adc_conversion_pkg::EVENT_MASK_ADDR);
    assign rd_status = access & ~pwrite & (paddr == adc_conversion_pkg::EVENT_STATUS_ADDR);

    // read mux; reserved bits and upper lanes read zero
    always_comb begin
        read_word = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            adc_conversion_pkg::CONTROL_ADDR: begin
                read_word[adc_conversion_pkg::CTRL_ENABLE_BIT] = converter_block_enable;
                read_word[adc_conversion_pkg::CTRL_EXT_START_BIT] = external_start_enable;
                read_word[adc_conversion_pkg::CTRL_DONE_BIT] = conversion_done_flag; // R10
                read_word[adc_conversion_pkg::CTRL_START_BIT] = conversion_start_busy; // R10
                read_word[adc_conversion_pkg::CTRL_CHAN_LSB +: adc_conversion_pkg::CHAN_W] =
                    input_channel_select;
            end
            adc_conversion_pkg::RESULT_HIGH_ADDR: begin
                read_word[7:0] = result[9:2]; // R11
            end
            adc_conversion_pkg::RESULT_LOW_ADDR: begin
                read_word[adc_conversion_pkg::LOW_CLKSEL_LSB +: adc_conversion_pkg::CLKSEL_W] =
                    conversion_clock_select;
                read_word[1:0] = result[1:0]; // R11
            end
            adc_conversion_pkg::EVENT_STATUS_ADDR: begin
                read_word[adc_conversion_pkg::EVT_W-1:0] = event_status;
            end
            adc_conversion_pkg::EVENT_MASK_ADDR: begin
                read_word[adc_conversion_pkg::EVT_W-1:0] = event_mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ready rises one cycle into the access phase; data and error go with it
    always_comb begin
        next_pready = psel & penable & ~pready;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (psel & penable & ~pready) begin
            next_prdata = pwrite ? 32'h0000_0000 : read_word;
            next_pslverr = ~mapped;
        end else if (pready) begin
            next_pslverr = 1'b0;
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // conversion control
    // ------------------------------------------------------------------
    // a control write sees its own enable and done-clear, so one write can
    // enable and start, or clear done and start in the same step
    always_comb begin
        en_now = wr_ctrl ? pwdata[adc_conversion_pkg::CTRL_ENABLE_BIT] : converter_block_enable;
        done_kept = conversion_done_flag &
                    ~(wr_ctrl & ~pwdata[adc_conversion_pkg::CTRL_DONE_BIT]);
        start_sw = wr_ctrl & pwdata[adc_conversion_pkg::CTRL_START_BIT] & en_now // R1 R14
                   & ~conversion_start_busy & ~done_kept; // R7 R9
        // control register writes have priority over a colliding trigger edge
        start_ext = ~wr_ctrl & trig_rise & external_start_enable // R2
                    & converter_block_enable & ~conversion_start_busy // R1 R7
                    & ~conversion_done_flag; // R7
        abort = conversion_start_busy &
                ((wr_ctrl & ~pwdata[adc_conversion_pkg::CTRL_START_BIT]) | ~en_now); // R6 R1
        complete = conversion_start_busy & core_done & ~abort;
        refused = (wr_ctrl & pwdata[adc_conversion_pkg::CTRL_START_BIT]
                   & ~conversion_start_busy & ~start_sw)
                  | (~wr_ctrl & trig_rise & external_start_enable & converter_block_enable
                     & (conversion_start_busy | conversion_done_flag));
        next_enable = en_now;
        next_ext_en = wr_ctrl ? pwdata[adc_conversion_pkg::CTRL_EXT_START_BIT]
                              : external_start_enable;
        next_chan = wr_ctrl ? pwdata[adc_conversion_pkg::CTRL_CHAN_LSB +: adc_conversion_pkg::CHAN_W]
                            : input_channel_select;
        // completion beats a same-cycle clear; only writes of zero clear
        next_done = complete | done_kept; // R3 R5
        next_busy = conversion_start_busy;
        if (abort) begin
            next_busy = 1'b0; // R6
        end else if (complete) begin
            next_busy = 1'b0; // R14
        end else if (start_sw | start_ext) begin
            next_busy = 1'b1; // R14
        end
        next_core_start = start_sw | start_ext;
        next_core_abort = abort;
        next_core_channel = (start_sw | start_ext) ? next_chan : core_channel; // R13
        next_result = complete ? core_result : result;
        clksel_raw = pwdata[adc_conversion_pkg::LOW_CLKSEL_LSB +: adc_conversion_pkg::CLKSEL_W];
        next_clksel = wr_low ? clksel_raw : conversion_clock_select; // R12
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_block_enable <= adc_conversion_pkg::CONTROL_RESET[adc_conversion_pkg::CTRL_ENABLE_BIT];
            external_start_enable <= adc_conversion_pkg::CONTROL_RESET[adc_conversion_pkg::CTRL_EXT_START_BIT];
            conversion_done_flag <= adc_conversion_pkg::CONTROL_RESET[adc_conversion_pkg::CTRL_DONE_BIT];
            conversion_start_busy <= adc_conversion_pkg::CONTROL_RESET[adc_conversion_pkg::CTRL_START_BIT];
            input_channel_select <= adc_conversion_pkg::CONTROL_RESET[2:0];
            conversion_clock_select <= adc_conversion_pkg::CLKSEL_RESET;
            result <= '0;
            core_start <= 1'b0;
            core_abort <= 1'b0;
            core_channel <= '0;
        end else begin
            converter_block_enable <= next_enable;
            external_start_enable <= next_ext_en;
            conversion_done_flag <= next_done;
            conversion_start_busy <= next_busy;
            input_channel_select <= next_chan;
            conversion_clock_select <= next_clksel;
            result <= next_result;
            core_start <= next_core_start;
            core_abort <= next_core_abort;
            core_channel <= next_core_channel;
        end
    end

    // ------------------------------------------------------------------
    // one-hot channel routing toward the analog mux
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < adc_conversion_pkg::CHANNELS; gi = gi + 1) begin : g_route
            assign next_input_enable[gi] = converter_block_enable
                & (next_core_channel == adc_conversion_pkg::CHAN_W'(gi)); // R13
        end
    endgenerate

    // ------------------------------------------------------------------
    // event status, mask and interrupt
    // ------------------------------------------------------------------
    // sticky events clear on a status read; a new event in that cycle wins
    always_comb begin
        evt_set = '0;
        evt_set[adc_conversion_pkg::EVT_DONE_BIT] = complete;
        evt_set[adc_conversion_pkg::EVT_ABORT_BIT] = abort;
        evt_set[adc_conversion_pkg::EVT_REFUSED_BIT] = refused;
        next_status = (rd_status ? '0 : event_status) | evt_set;
        next_mask = wr_mask ? pwdata[adc_conversion_pkg::EVT_W-1:0] : event_mask;
        // done-flag level keeps the request up until software clears it
        next_irq = (|(next_status & next_mask))
                   | (next_done & next_mask[adc_conversion_pkg::EVT_DONE_BIT]); // R4
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_status <= '0;
            event_mask <= adc_conversion_pkg::EVT_MASK_RESET;
            irq <= 1'b0;
            core_input_enable <= '0;
        end else begin
            event_status <= next_status;
            event_mask <= next_mask;
            irq <= next_irq;
            core_input_enable <= next_input_enable;
        end
    end

    // ------------------------------------------------------------------
    // conversion clock enable
    // ------------------------------------------------------------------
    // runs whenever the block is enabled so the core sees a steady rate
    conv_clock_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(converter_block_enable),
        .clock_select(conversion_clock_select),
        .tick(core_clk_en)
    );

endmodule : adc_conversion_control

/* File: bench/adc_core_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// behavioural analog core on the far side of the control block
// ------------------------------------------------------------
module adc_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic core_start,
    input wire logic core_abort,
    input wire logic core_clk_en,
    input wire logic slow,
    input wire logic [9:0] result_value,
    output logic core_done,
    output logic [9:0] core_result
);
    logic busy;
    logic [3:0] ticks;
    logic [9:0] held;
    // counts conversion clock ticks; an abort drops the conversion silently
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            ticks <= 4'h0;
            held <= 10'h0;
            core_done <= 1'b0;
        end else begin
            core_done <= 1'b0;
            if (core_abort) begin
                busy <= 1'b0;
            end else if (core_start) begin
                busy <= 1'b1;
                ticks <= slow ? 4'h6 : 4'h3;
                held <= result_value;
            end else if (busy && core_clk_en) begin
                ticks <= ticks - 4'h1;
                busy <= (ticks != 4'h1);
                core_done <= (ticks == 4'h1);
            end
        end
    end
    // outside the done cycle the inverse shows, so stale sampling is caught
    assign core_result = core_done ? held : ~held;
endmodule : adc_core_model

/* File: bench/adc_conversion_control_checker.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// port checker for the conversion control block
// ------------------------------------------------------------
module adc_conversion_control_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic core_start,
    input wire logic core_abort,
    input wire logic core_clk_en,
    input wire logic [adc_conversion_pkg::CHAN_W-1:0] core_channel,
    input wire logic [adc_conversion_pkg::CHANNELS-1:0] core_input_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // bus phases; the slave inserts exactly one wait state
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_apb_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready not after one wait");
    property p_ready_pulse; pready |-> s_access ##1 !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready outside access");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_tick_gap; core_clk_en |=> !core_clk_en [*3]; endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick gap below four");
    property p_tick_enabled; core_clk_en |-> core_input_enable != 8'h00; endproperty
    a_tick_enabled: assert property (p_tick_enabled) else $error("tick while off");
    property p_route; core_start |=> core_input_enable == (8'h01 << core_channel); endproperty
    a_route: assert property (p_route) else $error("input enable not channel");
    property p_no_restart; core_start |=> !core_start [*4]; endproperty
    a_no_restart: assert property (p_no_restart) else $error("start while busy");
    property p_abort_cause; core_abort |-> $past(pready) && $past(pwrite); endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("abort without write");
    // the done flag is only cleared by software, so irq only falls after a transfer
    property p_irq_fall; $fell(irq) |-> $past(pready) || $past(pready, 2) || $past(pready, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell by itself");
endmodule : adc_conversion_control_checker

bind adc_conversion_control adc_conversion_control_checker checker_inst (.clk, .rst_n,
    .psel, .penable, .pwrite, .pready, .pslverr, .irq, .core_start, .core_abort,
    .core_clk_en, .core_channel, .core_input_enable);

/* File: bench/tb_adc_conversion_control.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// self-checking bench for the conversion control block
// ------------------------------------------------------------
module tb_adc_conversion_control;
    localparam CTL = adc_conversion_pkg::CONTROL_ADDR;
    localparam RHI = adc_conversion_pkg::RESULT_HIGH_ADDR;
    localparam RLO = adc_conversion_pkg::RESULT_LOW_ADDR;
    localparam STS = adc_conversion_pkg::EVENT_STATUS_ADDR;
    localparam MSK = adc_conversion_pkg::EVENT_MASK_ADDR;
    localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, slow;
    logic external_trigger_pin, core_done, core_start, core_abort, core_clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] core_result, result_value;
    logic [2:0] core_channel, ch, c;
    logic [7:0] core_input_enable;
    logic [1:0] sel;
    logic [32:0] exp_q[$], msk_q[$];
    logic [2:0] start_q[$];
    int failures, samples_checked, aborts, n;
    adc_conversion_control adc_conversion_control_inst (.clk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .external_trigger_pin,
        .core_done, .core_result, .core_start, .core_abort, .core_channel,
        .core_input_enable, .core_clk_en);
    adc_core_model adc_core_model_inst (.clk, .rst_n, .core_start, .core_abort,
        .core_clk_en, .slow, .result_value, .core_done, .core_result);
    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, well beyond the expected run length
    initial begin
        #300000;
        failures++;
        final_report();
    end
    task automatic check_bits(input logic [32:0] got, input logic [32:0] exp,
                              input logic [32:0] msk);
        samples_checked++;
        if (((got ^ exp) & msk) !== 33'h0) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bits
    task automatic check_count(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            failures++;
            $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : check_count
    task automatic final_report();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // one transfer; the expected answer is queued for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0, ALL);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, {25'h0, e}, ALL);
    endtask : rd
    // pin edge with the bus idle, so no control write collides with it
    task automatic pulse_pin();
        @(posedge clk);
        external_trigger_pin <= 1'b1;
        repeat (6) @(posedge clk);
        external_trigger_pin <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse_pin
    task automatic wait_irq();
        while (irq !== 1'b1) @(posedge clk);
    endtask : wait_irq
    // monitor: bus answers and core starts against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            check_bits({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
        end
        if (core_start === 1'b1) begin
            c = (start_q.size() > 0) ? start_q.pop_front() : ~core_channel;
            check_bits({30'h0, core_channel}, {30'h0, c}, ALL);
        end
        if (core_abort === 1'b1) aborts++;
    end
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, external_trigger_pin, slow} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        result_value = 10'h0;
        void'($urandom(91720));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(CTL, 8'h00);
        rd(RLO, 8'h00);
        rd(RHI, 8'h00);
        rd(STS, 8'h00);
        rd(MSK, 8'h00);
        apb(1'b0, 12'h100, 8'h00, 33'h1_0000_0000, ALL);
        wr(CTL, 8'h08);
        apb(1'b0, STS, 8'h00, 33'h0, 33'h1_FFFF_FFFB);
        wr(MSK, 8'h01);
        for (int i = 0; i < 8; i++) begin
            ch = 3'(i);
            sel = 2'($urandom);
            result_value <= 10'($urandom);
            slow <= i[0];
            wr(RLO, {sel, 6'h0});
            wr(CTL, {5'h10, ch});
            while (core_clk_en !== 1'b1) @(posedge clk);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (core_clk_en !== 1'b1);
            check_count(n, (sel == 2'h0) ? 4 : (sel == 2'h1) ? 8 : 16);
            start_q.push_back(ch);
            wr(CTL, 8'h88 | ch);
            rd(CTL, 8'h88 | ch);
            if (i[0]) wr(CTL, 8'h88 | ch);
            wait_irq();
            rd(CTL, 8'h90 | ch);
            rd(RHI, result_value[9:2]);
            rd(RLO, {sel, 4'h0, result_value[1:0]});
            wr(CTL, 8'h98 | ch);
            rd(CTL, 8'h90 | ch);
            rd(STS, 8'h05);
            wr(CTL, 8'h80 | ch);
        end
        ch = 3'($urandom);
        start_q.push_back(ch);
        wr(CTL, 8'h88 | ch);
        wait_irq();
        start_q.push_back(ch);
        wr(CTL, 8'h88 | ch);
        rd(CTL, 8'h88 | ch);
        wr(CTL, 8'h80);
        rd(CTL, 8'h80);
        start_q.push_back(3'h0);
        wr(CTL, 8'h88);
        wr(CTL, 8'h00);
        rd(STS, 8'h03);
        check_count(aborts, 2);
        wr(CTL, 8'h80);
        pulse_pin();
        ch = 3'($urandom);
        wr(CTL, 8'hA0 | ch);
        start_q.push_back(ch);
        pulse_pin();
        wait_irq();
        rd(CTL, 8'hB0 | ch);
        pulse_pin();
        rd(STS, 8'h05);
        wr(MSK, 8'h00);
        wr(CTL, 8'hA0 | ch);
        start_q.push_back(ch);
        pulse_pin();
        while (core_done !== 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
        check_bits({32'h0, irq}, 33'h0, ALL);
        wr(MSK, 8'h01);
        repeat (3) @(posedge clk);
        check_bits({32'h0, irq}, 33'h1, ALL);
        check_count(start_q.size(), 0);
        final_report();
    end
endmodule : tb_adc_conversion_control
